// >>> inc/aperture_delay_pkg.sv
// package: register map, field layout, reset values, timing counts and carriers
package aperture_delay_pkg;

    // ------------------------------------------------------------------
    // register bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 24;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] SYSREF_CAL_STATUS_ADDR = 12'h2B2;
    localparam logic [11:0] APERTURE_DELAY_CTRL_ADDR = 12'h2B5;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CAL_DONE_BIT = 17;
    localparam int INVERT_BIT = 16;
    localparam int COARSE_MSB = 15;
    localparam int COARSE_LSB = 8;
    localparam int FINE_MSB = 7;
    localparam int FINE_LSB = 0;
    localparam int DELAY_W = 17;
    localparam int STEP_W = 8;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [16:0] CTRL_RESET = 17'h00000;
    localparam logic [16:0] CAL_VALUE_RESET = 17'h00000;
    localparam logic [23:0] READ_ZERO = 24'h000000;

    // ------------------------------------------------------------------
    // timing counts, in sampling-clock cycles, and ramp step sizes, in codes
    // ------------------------------------------------------------------
    localparam int RAMP_PERIOD_CYCLES = 384;
    localparam int APPLY_LIMIT_CYCLES = 1536;
    localparam int RAMP_STEP_SLOW = 1;
    localparam int RAMP_STEP_FAST = 4;
    localparam int RAMP_CNT_W = $clog2(RAMP_PERIOD_CYCLES);

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic invert;
        logic [STEP_W-1:0] coarse;
        logic [STEP_W-1:0] fine;
    } delay_t;

    typedef struct packed {
        logic finish;
        logic [DELAY_W-1:0] value;
    } cal_result_t;

endpackage

// >>> src/delay_coarse_ramp.sv
// module: steps the applied coarse delay toward its target on a fixed period
`timescale 1ns/1ps
module delay_coarse_ramp #(
    parameter int PERIOD = aperture_delay_pkg::RAMP_PERIOD_CYCLES,
    parameter int STEP_FAST = aperture_delay_pkg::RAMP_STEP_FAST
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] target,
    input wire logic ramp_en,
    input wire logic ramp_fast,
    output logic [7:0] applied_r
);

    typedef struct packed {
        logic [aperture_delay_pkg::RAMP_CNT_W-1:0] cnt;
        logic [7:0] applied;
    } ramp_state_t;

    localparam logic [aperture_delay_pkg::RAMP_CNT_W-1:0] CNT_TOP =
        aperture_delay_pkg::RAMP_CNT_W'(PERIOD - 1);
    localparam logic [7:0] STEP_BIG = 8'(STEP_FAST);
    localparam logic [7:0] STEP_ONE = 8'(aperture_delay_pkg::RAMP_STEP_SLOW);

    ramp_state_t s_r;
    ramp_state_t s_nxt;
    logic [7:0] step;

    always_comb begin
        s_nxt = s_r;
        step = ramp_fast ? STEP_BIG : STEP_ONE;
        if (s_r.cnt == '0) begin
            s_nxt.cnt = CNT_TOP;
            if (!ramp_en) begin
                s_nxt.applied = target;
            end else if (target > s_r.applied) begin
                s_nxt.applied = (8'(target - s_r.applied) > step) ?
                    8'(s_r.applied + step) : target;
            end else if (target < s_r.applied) begin
                s_nxt.applied = (8'(s_r.applied - target) > step) ?
                    8'(s_r.applied - step) : target;
            end
        end else begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign applied_r = s_r.applied;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_direct_apply;
        @(posedge clk_sys) disable iff (rst)
        (s_r.cnt == '0 && !ramp_en) |=> applied_r == $past(target);
    endproperty
    a_direct_apply: assert property (p_direct_apply) else $error("coarse not applied");

    property p_ramp_step;
        @(posedge clk_sys) disable iff (rst)
        ramp_en |=> (applied_r >= $past(applied_r) ?
            (applied_r - $past(applied_r)) : ($past(applied_r) - applied_r))
            <= (($past(ramp_fast)) ? STEP_BIG : STEP_ONE);
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("ramp step too large");

    property p_hold_between_ticks;
        @(posedge clk_sys) disable iff (rst)
        (s_r.cnt != '0) |=> $stable(applied_r);
    endproperty
    a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("moved early");

    c_ramp_moves: cover property (@(posedge clk_sys) disable iff (rst)
        ramp_en && s_r.cnt == '0 && target != applied_r);

endmodule

// >>> src/aperture_delay_control.sv
// module: sampling aperture delay control with calibrated and manual sources
`timescale 1ns/1ps

// Summary of operation
// - done bit reads 1 only while calibration enabled and sequence finished
// - status word carries the 17-bit calibrated delay; valid only when done
// - calibrated value: bit 16 invert, 15:8 coarse, 7:0 finer delay
// - manual bit 16 set inverts the sampling clock, clear leaves it
// - calibration off: manual bits 15:8 set the coarse delay step
// - calibration off: manual bits 7:0 set the fine delay step
// - fine delay accepted anytime and applied without a glitch
// - coarse limit met by small host writes or by the ramp
// - manual delay register resets to zero
// - rising calibration enable starts the calibration sequence
// - calibration enabled uses calibrated delay, else the manual register
// - ramp moves coarse one or four codes every 384 cycles
// - ramp off: written coarse applied within 1536 cycles
module aperture_delay_control (
    input wire logic clk_sys,
    input wire logic rst,
    input aperture_delay_pkg::reg_req_t reg_req,
    output logic [aperture_delay_pkg::DATA_W-1:0] rd_data_r,
    output logic rd_valid_r,
    input wire logic sysref_cal_enable,
    input wire logic adc_cal_enable,
    input wire logic serial_link_enable,
    input wire logic ramp_en,
    input wire logic ramp_fast,
    input aperture_delay_pkg::cal_result_t cal_result,
    output logic cal_start_r,
    output logic sample_clock_invert_r,
    output logic [aperture_delay_pkg::STEP_W-1:0] coarse_applied_r,
    output logic [aperture_delay_pkg::STEP_W-1:0] fine_applied_r,
    output logic coarse_settled_r
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        aperture_delay_pkg::delay_t ctrl;
        logic cal_done;
        logic [aperture_delay_pkg::DELAY_W-1:0] cal_value;
        logic cal_en_d;
        logic cal_start;
        logic [aperture_delay_pkg::DATA_W-1:0] rd_data;
        logic rd_valid;
        logic invert;
        logic [aperture_delay_pkg::STEP_W-1:0] coarse_target;
        logic [aperture_delay_pkg::STEP_W-1:0] fine;
        logic settled;
    } ctl_state_t;

    ctl_state_t s_r;
    ctl_state_t s_nxt;
    aperture_delay_pkg::delay_t cal_delay;
    aperture_delay_pkg::delay_t src_delay;
    logic ctrl_hit;
    logic stat_hit;
    logic run_active;
    logic [aperture_delay_pkg::STEP_W-1:0] coarse_now;

    assign ctrl_hit = reg_req.addr == aperture_delay_pkg::APERTURE_DELAY_CTRL_ADDR;
    assign stat_hit = reg_req.addr == aperture_delay_pkg::SYSREF_CAL_STATUS_ADDR;
    // host keeps the invert bit and coarse steps within limits while this is set
    assign run_active = adc_cal_enable | serial_link_enable;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        cal_delay = aperture_delay_pkg::delay_t'(s_r.cal_value);
        src_delay = sysref_cal_enable ? cal_delay : s_r.ctrl;

        // manual register write
        if (reg_req.wr && ctrl_hit) begin
            s_nxt.ctrl = aperture_delay_pkg::delay_t'(
                reg_req.wdata[aperture_delay_pkg::DELAY_W-1:0]);
        end

        // calibration start and completion
        // a dropped enable or a new start wins over a same-cycle finish
        s_nxt.cal_en_d = sysref_cal_enable;
        s_nxt.cal_start = sysref_cal_enable & ~s_r.cal_en_d;
        if (!sysref_cal_enable || s_nxt.cal_start) begin
            s_nxt.cal_done = 1'b0;
        end else if (cal_result.finish) begin
            s_nxt.cal_done = 1'b1;
            s_nxt.cal_value = cal_result.value;
        end

        // applied delay selection
        s_nxt.invert = src_delay.invert;
        s_nxt.coarse_target = src_delay.coarse;
        s_nxt.fine = src_delay.fine;
        s_nxt.settled = coarse_now == s_r.coarse_target;

        // register read
        s_nxt.rd_valid = reg_req.rd;
        s_nxt.rd_data = aperture_delay_pkg::READ_ZERO;
        if (reg_req.rd && ctrl_hit) begin
            s_nxt.rd_data = {7'h00, s_r.ctrl};
        end else if (reg_req.rd && stat_hit) begin
            s_nxt.rd_data = {6'h00, s_r.cal_done, s_r.cal_value};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // coarse ramp
    // ------------------------------------------------------------------
    delay_coarse_ramp #(
        .PERIOD(aperture_delay_pkg::RAMP_PERIOD_CYCLES),
        .STEP_FAST(aperture_delay_pkg::RAMP_STEP_FAST)
    ) u_ramp (
        .clk_sys(clk_sys),
        .rst(rst),
        .target(s_r.coarse_target),
        .ramp_en(ramp_en),
        .ramp_fast(ramp_fast),
        .applied_r(coarse_now)
    );

    assign rd_data_r = s_r.rd_data;
    assign rd_valid_r = s_r.rd_valid;
    assign cal_start_r = s_r.cal_start;
    assign sample_clock_invert_r = s_r.invert;
    assign coarse_applied_r = coarse_now;
    assign fine_applied_r = s_r.fine;
    assign coarse_settled_r = s_r.settled;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_done_needs_enable;
        s_r.cal_done |-> $past(sysref_cal_enable);
    endproperty
    a_done_needs_enable: assert property (p_done_needs_enable) else $error("stray done");

    property p_done_clears;
        !sysref_cal_enable |=> !s_r.cal_done ##1 (!s_r.cal_done || $past(sysref_cal_enable));
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("done not cleared");

    property p_start_on_rise;
        sysref_cal_enable && !s_r.cal_en_d |=> cal_start_r ##1 !cal_start_r;
    endproperty
    a_start_on_rise: assert property (p_start_on_rise) else $error("start pulse wrong");

    property p_value_capture;
        sysref_cal_enable && s_r.cal_en_d && cal_result.finish
            |=> s_r.cal_done && s_r.cal_value == $past(cal_result.value);
    endproperty
    a_value_capture: assert property (p_value_capture) else $error("value not captured");

    property p_read_status;
        reg_req.rd && stat_hit |=> rd_valid_r &&
            rd_data_r == {6'h00, $past(s_r.cal_done), $past(s_r.cal_value)};
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read wrong");

    property p_manual_fine;
        !sysref_cal_enable |=> fine_applied_r == $past(s_r.ctrl.fine);
    endproperty
    a_manual_fine: assert property (p_manual_fine) else $error("fine not applied");

    property p_manual_invert;
        !sysref_cal_enable |=> sample_clock_invert_r == $past(s_r.ctrl.invert);
    endproperty
    a_manual_invert: assert property (p_manual_invert) else $error("invert not manual");

    property p_cal_source;
        sysref_cal_enable |=> s_r.coarse_target == $past(s_r.cal_value[15:8]) &&
            sample_clock_invert_r == $past(s_r.cal_value[16]);
    endproperty
    a_cal_source: assert property (p_cal_source) else $error("calibrated source unused");

    property p_ctrl_write;
        reg_req.wr && ctrl_hit |=> s_r.ctrl.coarse == $past(reg_req.wdata[15:8]) &&
            s_r.ctrl.fine == $past(reg_req.wdata[7:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl write lost");

    property p_reset_zero;
        @(posedge clk_sys) disable iff (1'b0) rst |=> s_r.ctrl == aperture_delay_pkg::CTRL_RESET;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("ctrl not zero");

    // ------------------------------------------------------------------
    // checks: calibration start and status
    // ------------------------------------------------------------------
    property p_start_once;
        cal_start_r |=> !cal_start_r;
    endproperty
    a_start_once: assert property (p_start_once) else $error("start too long");

    property p_start_rise;
        cal_start_r |-> $past(sysref_cal_enable) && !$past(s_r.cal_en_d);
    endproperty
    a_start_rise: assert property (p_start_rise) else $error("start without rise");

    property p_start_clear;
        cal_start_r |-> !s_r.cal_done;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("done kept");

    // a finished calibration stays reported until the enable drops
    property p_done_holds;
        s_r.cal_done && sysref_cal_enable |=> s_r.cal_done;
    endproperty
    a_done_holds: assert property (p_done_holds) else $error("done lost");

    property p_done_finish;
        $rose(s_r.cal_done) |-> $past(cal_result.finish);
    endproperty
    a_done_finish: assert property (p_done_finish) else $error("done without finish");

    property p_value_holds;
        !cal_result.finish |=> $stable(s_r.cal_value);
    endproperty
    a_value_holds: assert property (p_value_holds) else $error("value changed");

    // ------------------------------------------------------------------
    // checks: register port
    // ------------------------------------------------------------------
    property p_read_ctrl;
        reg_req.rd && ctrl_hit |=> rd_valid_r &&
            rd_data_r == {7'h00, $past(s_r.ctrl)};
    endproperty
    a_read_ctrl: assert property (p_read_ctrl) else $error("ctrl read wrong");

    // unmapped addresses and idle cycles read as zero
    property p_read_other;
        reg_req.rd && !ctrl_hit && !stat_hit |=> rd_valid_r &&
            rd_data_r == aperture_delay_pkg::READ_ZERO;
    endproperty
    a_read_other: assert property (p_read_other) else $error("unmapped read");

    property p_read_idle;
        !reg_req.rd |=> !rd_valid_r && rd_data_r == aperture_delay_pkg::READ_ZERO;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("stray read data");

    property p_valid_source;
        rd_valid_r |-> $past(reg_req.rd);
    endproperty
    a_valid_source: assert property (p_valid_source) else $error("stray valid");

    property p_wr_refused;
        !(reg_req.wr && ctrl_hit) |=> $stable(s_r.ctrl);
    endproperty
    a_wr_refused: assert property (p_wr_refused) else $error("ctrl overwritten");

    // ------------------------------------------------------------------
    // checks: applied delay
    // ------------------------------------------------------------------
    property p_manual_coarse;
        !sysref_cal_enable |=> s_r.coarse_target == $past(s_r.ctrl.coarse);
    endproperty
    a_manual_coarse: assert property (p_manual_coarse) else $error("coarse not manual");

    property p_cal_fine;
        sysref_cal_enable |=> fine_applied_r == $past(s_r.cal_value[7:0]);
    endproperty
    a_cal_fine: assert property (p_cal_fine) else $error("fine not calibrated");

    // fine moves freely, even while running; it lands two edges after the write
    property p_fine_anytime;
        reg_req.wr && ctrl_hit && !sysref_cal_enable ##1 !sysref_cal_enable
            |=> fine_applied_r == $past(reg_req.wdata[7:0], 2);
    endproperty
    a_fine_anytime: assert property (p_fine_anytime) else $error("fine write lost");

    property p_cal_ignores;
        sysref_cal_enable && $past(sysref_cal_enable) && $stable(s_r.cal_value)
            |=> $stable(fine_applied_r) && $stable(sample_clock_invert_r);
    endproperty
    a_cal_ignores: assert property (p_cal_ignores) else $error("manual leaked");

    property p_settled;
        coarse_settled_r |-> $past(coarse_now) == $past(s_r.coarse_target);
    endproperty
    a_settled: assert property (p_settled) else $error("settled wrong");

    c_cal_done: cover property ($rose(s_r.cal_done));
    c_ctrl_write: cover property (reg_req.wr && ctrl_hit && run_active);
    c_status_read: cover property (reg_req.rd && stat_hit && s_r.cal_done);
    c_done_drop: cover property ($fell(s_r.cal_done));

endmodule

// >>> verif/host_model.sv
// host model: drives register accesses on the parallel strobe port
`timescale 1ns/1ps
module host_model (
    input wire logic clk_sys,
    input wire logic [23:0] rd_data_r,
    input wire logic rd_valid_r,
    output aperture_delay_pkg::reg_req_t reg_req
);
    int gap = 0;
    logic [16:0] ctrl_shadow = 17'h00000;

    initial begin
        reg_req = '0;
    end

    // released address and data show the inverse of the last value
    task automatic write_reg(input logic [11:0] addr, input logic [23:0] data);
        repeat (gap) @(posedge clk_sys);
        @(posedge clk_sys);
        #1;
        reg_req.wr = 1'b1;
        reg_req.addr = addr;
        reg_req.wdata = data;
        @(posedge clk_sys);
        #1;
        reg_req.wr = 1'b0;
        reg_req.addr = ~addr;
        reg_req.wdata = ~data;
        if (addr == aperture_delay_pkg::APERTURE_DELAY_CTRL_ADDR) begin
            ctrl_shadow = data[16:0];
        end
    endtask

    task automatic read_reg(input logic [11:0] addr, output logic [23:0] data,
                            output logic valid);
        repeat (gap) @(posedge clk_sys);
        @(posedge clk_sys);
        #1;
        reg_req.rd = 1'b1;
        reg_req.addr = addr;
        @(posedge clk_sys);
        #1;
        reg_req.rd = 1'b0;
        reg_req.addr = ~addr;
        data = rd_data_r;
        valid = rd_valid_r;
    endtask

    // while running: one code per write, inversion bit left as it was
    task automatic step_coarse(input logic [7:0] target);
        logic [16:0] v;
        v = ctrl_shadow;
        while (v[15:8] != target) begin
            v[15:8] = (v[15:8] < target) ? v[15:8] + 8'h01 : v[15:8] - 8'h01;
            write_reg(aperture_delay_pkg::APERTURE_DELAY_CTRL_ADDR, {7'h00, v});
        end
    endtask
endmodule

// >>> verif/aperture_delay_control_bench.sv
// bench: self-checking test of the aperture delay control block
`timescale 1ns/1ps
module aperture_delay_control_bench;
    localparam logic [11:0] A_CTRL = aperture_delay_pkg::APERTURE_DELAY_CTRL_ADDR;
    localparam logic [11:0] A_STAT = aperture_delay_pkg::SYSREF_CAL_STATUS_ADDR;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic sysref_cal_enable = 1'b0;
    logic adc_cal_enable = 1'b0;
    logic serial_link_enable = 1'b0;
    logic ramp_en = 1'b0;
    logic ramp_fast = 1'b0;
    aperture_delay_pkg::cal_result_t cal_result = '0;
    aperture_delay_pkg::reg_req_t reg_req;
    logic [23:0] rd_data_r;
    logic rd_valid_r;
    logic cal_start_r;
    logic sample_clock_invert_r;
    logic coarse_settled_r;
    logic [7:0] coarse_applied_r;
    logic [7:0] fine_applied_r;
    int mismatches = 0;
    int n_tests = 0;
    logic [31:0] w;
    logic [23:0] rdata;
    logic rvalid;

    always #20 clk_sys = ~clk_sys;

    aperture_delay_control aperture_delay_control_inst (.clk_sys(clk_sys), .rst(rst),
        .reg_req(reg_req), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
        .sysref_cal_enable(sysref_cal_enable), .adc_cal_enable(adc_cal_enable),
        .serial_link_enable(serial_link_enable), .ramp_en(ramp_en), .ramp_fast(ramp_fast),
        .cal_result(cal_result), .cal_start_r(cal_start_r),
        .sample_clock_invert_r(sample_clock_invert_r), .coarse_applied_r(coarse_applied_r),
        .fine_applied_r(fine_applied_r), .coarse_settled_r(coarse_settled_r));

    host_model host_model_inst (.clk_sys(clk_sys), .rd_data_r(rd_data_r),
        .rd_valid_r(rd_valid_r), .reg_req(reg_req));

    // ------------------------------------------------------------------
    // compare and helper tasks
    // ------------------------------------------------------------------
    task automatic check_word(input logic [23:0] got, input logic [23:0] exp, input string s);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, s, got, exp);
        end
    endtask

    task automatic check_out(input logic [7:0] got, input logic [7:0] exp, input string s);
        check_word({16'h0000, got}, {16'h0000, exp}, s);
    endtask

    task automatic read_check(input logic [11:0] a, input logic [23:0] exp);
        host_model_inst.read_reg(a, rdata, rvalid);
        check_out({7'h00, rvalid}, 8'h01, "read valid");
        check_word(rdata, exp, "read data");
    endtask

    function automatic logic [7:0] step_toward(logic [7:0] cur, logic [7:0] tgt, int step);
        if (tgt > cur) begin
            return (tgt - cur > step) ? cur + 8'(step) : tgt;
        end
        return (cur - tgt > step) ? cur - 8'(step) : tgt;
    endfunction

    // each change of the applied coarse value must be one ramp step
    task automatic ramp_check(input logic [7:0] tgt, input int step);
        logic [7:0] prev;
        int n;
        // let a fresh write reach the ramp's target before watching steps
        repeat (2) @(posedge clk_sys);
        #1;
        while (coarse_applied_r !== tgt) begin
            prev = coarse_applied_r;
            n = 0;
            while (coarse_applied_r === prev && n < 1536) begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            check_out(coarse_applied_r, step_toward(prev, tgt, step), "coarse step");
            if (n >= 1536) begin
                return;
            end
        end
        @(posedge clk_sys);
        #1;
        check_out({7'h00, coarse_settled_r}, 8'h01, "settled");
    endtask

    task automatic final_report;
        $display("counts: %0d comparisons, %0d mismatches", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h9428));
        repeat (16) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        read_check(A_CTRL, 24'h000000);
        read_check(A_STAT, 24'h000000);
        check_out({sample_clock_invert_r, coarse_applied_r[6:0]}, 8'h00, "reset out");
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            host_model_inst.gap = $urandom_range(0, 2);
            w = $urandom;
            host_model_inst.write_reg(A_CTRL, w[23:0]);
            read_check(A_CTRL, {7'h00, w[16:0]});
            check_out({7'h00, sample_clock_invert_r}, {7'h00, w[16]}, "invert");
            check_out(fine_applied_r, w[7:0], "fine");
        end
        host_model_inst.write_reg(A_STAT, 24'hFFFFFF);
        read_check(A_STAT, 24'h000000);
        read_check(12'h2B3, 24'h000000);
        ramp_check(w[15:8], 256);
        $display("test manual done");
        host_model_inst.write_reg(A_CTRL, 24'h001000);
        ramp_check(8'h10, 256);
        ramp_en = 1'b1;
        host_model_inst.write_reg(A_CTRL, 24'h0013A5);
        ramp_check(8'h13, 1);
        ramp_fast = 1'b1;
        host_model_inst.write_reg(A_CTRL, 24'h0006A5);
        ramp_check(8'h06, 4);
        ramp_en = 1'b0;
        $display("test ramp done");
        adc_cal_enable = 1'b1;
        serial_link_enable = 1'b1;
        host_model_inst.step_coarse(8'h09);
        ramp_check(8'h09, 256);
        w = $urandom;
        host_model_inst.write_reg(A_CTRL, {16'h0009, w[7:0]});
        read_check(A_CTRL, {16'h0009, w[7:0]});
        check_out(fine_applied_r, w[7:0], "fine running");
        adc_cal_enable = 1'b0;
        serial_link_enable = 1'b0;
        $display("test running done");
        cal_result = {1'b1, 17'h1ABCD};
        @(posedge clk_sys);
        #1;
        cal_result = '0;
        read_check(A_STAT, 24'h000000);
        sysref_cal_enable = 1'b1;
        @(posedge clk_sys);
        #1;
        check_out({7'h00, cal_start_r}, 8'h01, "cal start");
        @(posedge clk_sys);
        #1;
        check_out({7'h00, cal_start_r}, 8'h00, "cal start pulse");
        read_check(A_STAT, 24'h000000);
        w = $urandom;
        cal_result = {1'b1, w[16:0]};
        @(posedge clk_sys);
        #1;
        cal_result = '0;
        read_check(A_STAT, {6'h00, 1'b1, w[16:0]});
        check_out({7'h00, sample_clock_invert_r}, {7'h00, w[16]}, "cal invert");
        check_out(fine_applied_r, w[7:0], "cal fine");
        ramp_check(w[15:8], 256);
        host_model_inst.write_reg(A_CTRL, {8'h00, ~w[15:0]});
        check_out(fine_applied_r, w[7:0], "manual ignored");
        sysref_cal_enable = 1'b0;
        host_model_inst.read_reg(A_STAT, rdata, rvalid);
        check_out({7'h00, rdata[17]}, 8'h00, "done cleared");
        check_out(fine_applied_r, ~w[7:0], "manual back");
        $display("test calibration done");
        final_report;
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        final_report;
    end
endmodule
